// ### core/pccs_command_status.sv
// Bus command and status register bank with the gates it drives
// Overview of operation
// - I/O space enable reads zero, never claimed
// - Memory enable clear blocks memory claims
// - Master enable clear blocks bus requests
// - Special cycles seen only when enabled
// - Invalidate and back-to-back enables read zero
// - Palette snoop and stepping bits read zero
// - Parity response enable gates parity pin
// - System error enable gates system error pin
// - Back-to-back capable status reads zero
// - Parity reported needs pin, mastership, enable
// - Decode timing status reads medium, 01
// - Signalled target abort sets its flag
// - Received target abort sets its flag
// - Own master abort sets its flag
// - Driving system error sets its flag
// - Any detected parity error sets flag
// - Cache line size reads zero, ignores writes
// - Latency limit used only after grant loss
// - Latency limit cleared by hardware reset only
// - Self test register reads zero
// - System error pin drive halts device
`default_nettype none
module pccs_command_status (
   // Clock and resets
   input wire logic core_clk,
   input wire logic rst,
   input wire logic swReset,
   // Configuration access
   input wire pccs_pkg::pccs_cfg_req_t cfgReq,
   output logic [31:0] cfgRdData,
   output logic cfgRdValid,
   // Events from target and master units
   input wire pccs_pkg::pccs_evt_t evt,
   // Requests to be gated
   input wire logic memDecodeHit,
   input wire logic masterWant,
   input wire logic specialCycleCmd,
   // Bus pins active low; output enables active high
   input wire logic busGrantPinN,
   input wire logic framePinN,
   input wire logic parityErrorPinInN,
   output logic parityErrorPinOutN,
   output logic parityErrorPinOe,
   output logic systemErrorPinOutN,
   output logic systemErrorPinOe,
   // Gated results
   output logic memClaim,
   output logic busRequest,
   output logic specialCycleSeen,
   output logic burstEnd,
   output logic deviceHalted
);
   import pccs_pkg::*;

   pccs_state_t s_reg;
   pccs_state_t s_next;
   logic [15:0] clrMask;
   logic [15:0] setMask;
   logic [15:0] cmdWrMask;

   // Expands two byte enables into a 16-bit lane mask
   function automatic logic [15:0] laneMask(input logic [1:0] be);
      laneMask = {{8{be[1]}}, {8{be[0]}}};
   endfunction

   // Increments without wrapping so long bursts still expire
   function automatic logic [7:0] satInc(input logic [7:0] v);
      satInc = (v == 8'hFF) ? v : v + 8'h01;
   endfunction

   always_comb begin
      s_next = s_reg;
      s_next.rdValid = 1'b0;
      s_next.burstEnd = 1'b0;
      s_next.perrOe = 1'b0;
      s_next.serrOe = 1'b0;
      clrMask = 16'h0000;
      setMask = 16'h0000;
      cmdWrMask = 16'h0000;

      // Command and status writes
      if (cfgReq.wr && cfgReq.addr == CFG_CMD_STAT_OFS) begin
         cmdWrMask = laneMask(cfgReq.be[1:0]) & CMD_WR_MASK;
         s_next.cmd = (s_reg.cmd & ~cmdWrMask) |
            (cfgReq.data[15:0] & cmdWrMask);
         clrMask = laneMask(cfgReq.be[3:2]) & cfgReq.data[31:16] &
            ST_EVT_MASK;
      end
      // Only the latency byte of that word holds state
      if (cfgReq.wr && cfgReq.addr == CFG_LAT_OFS && cfgReq.be[1]) begin
         s_next.latency = cfgReq.data[15:8];
      end

      // Parity handling
      s_next.perrOe = evt.parityDetected &&
         s_reg.cmd[CMD_PARITY_BIT];
      setMask[ST_PAR_DET_BIT] = evt.parityDetected;
      setMask[ST_PAR_REP_BIT] = (s_reg.perrOe || !parityErrorPinInN) &&
         evt.isMaster && s_reg.cmd[CMD_PARITY_BIT];
      setMask[ST_SIG_TA_BIT] = evt.targetAbortSent;
      setMask[ST_RCV_TA_BIT] = evt.targetAbortRecv;
      setMask[ST_MA_BIT] = evt.masterAbortSent;

      // System error: one pulse on the pin, halted from that same cycle
      s_next.sysErrFlag = s_reg.sysErrFlag | evt.sysErrCond;
      if (s_reg.health == DEV_RUN && s_reg.sysErrFlag &&
         s_reg.cmd[CMD_SERR_BIT]) begin
         s_next.serrOe = 1'b1;
         s_next.health = DEV_HALTED;
         setMask[ST_SERR_BIT] = 1'b1;
      end

      // Set wins over a clear arriving in the same cycle
      s_next.stat = ((s_reg.stat & ~clrMask) | setMask) & ST_EVT_MASK;

      // Gates; a halted device neither claims nor masters
      s_next.memClaim = memDecodeHit && s_reg.cmd[CMD_MEM_BIT] &&
         s_reg.health == DEV_RUN;
      s_next.busRequest = masterWant && s_reg.cmd[CMD_MASTER_BIT] &&
         s_reg.health == DEV_RUN;
      s_next.specialSeen = specialCycleCmd &&
         s_reg.cmd[CMD_SPECIAL_BIT];

      // Latency limit counted from the frame start
      unique case (s_reg.burst)
         BURST_IDLE: begin
            if (evt.isMaster && !framePinN) begin
               s_next.latCount = LAT_COUNT_START;
               s_next.burst = busGrantPinN ? BURST_RELEASED :
                  BURST_GRANTED;
            end
         end
         BURST_GRANTED: begin
            // Limit is ignored while the grant stays on
            s_next.latCount = satInc(s_reg.latCount);
            if (framePinN) begin
               s_next.burst = BURST_IDLE;
            end else if (busGrantPinN) begin
               s_next.burst = BURST_RELEASED;
            end
         end
         BURST_RELEASED: begin
            s_next.latCount = satInc(s_reg.latCount);
            if (framePinN) begin
               s_next.burst = BURST_IDLE;
            end else if (s_reg.latCount >= s_reg.latency) begin
               s_next.burstEnd = 1'b1;
               s_next.burst = BURST_IDLE;
            end
         end
         default: begin
            s_next.burst = BURST_IDLE;
         end
      endcase

      // Reads see the values before any write of the same cycle
      if (cfgReq.rd) begin
         s_next.rdValid = 1'b1;
         s_next.rdCmd = cfgReq.addr == CFG_CMD_STAT_OFS;
         s_next.rdLat = cfgReq.addr == CFG_LAT_OFS;
         unique case (cfgReq.addr)
            CFG_CMD_STAT_OFS: begin
               s_next.rdData = {s_reg.stat | ST_RO_VALUE,
                  s_reg.cmd};
            end
            CFG_LAT_OFS: begin
               s_next.rdData = {SELF_TEST_VALUE, HEADER_TYPE_VALUE,
                  s_reg.latency, CACHE_LINE_VALUE};
            end
            default: begin
               s_next.rdData = 32'h0000_0000;
            end
         endcase
      end

      // Software reset keeps the latency limit
      if (swReset) begin
         s_next = STATE_RESET;
         s_next.latency = s_reg.latency;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_reg <= STATE_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign cfgRdData = s_reg.rdData;
   assign cfgRdValid = s_reg.rdValid;
   assign memClaim = s_reg.memClaim;
   assign busRequest = s_reg.busRequest;
   assign specialCycleSeen = s_reg.specialSeen;
   assign burstEnd = s_reg.burstEnd;
   assign deviceHalted = s_reg.health == DEV_HALTED;
   assign parityErrorPinOe = s_reg.perrOe;
   assign systemErrorPinOe = s_reg.serrOe;
   // Open-drain style pins only ever pull low
   assign parityErrorPinOutN = 1'b0;
   assign systemErrorPinOutN = 1'b0;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   a_cmd_zero_bits: assert property (
      cfgRdValid && s_reg.rdCmd |-> cfgRdData[15:9] == 7'h00 &&
      cfgRdData[7] == 1'b0 && cfgRdData[5:4] == 2'b00 &&
      cfgRdData[0] == 1'b0)
      else $error("hardwired command bit read nonzero");
   a_status_const: assert property (
      cfgRdValid && s_reg.rdCmd |-> cfgRdData[26:25] == 2'b01 &&
      cfgRdData[23:16] == 8'h00)
      else $error("status constant field wrong");
   a_cache_selftest: assert property (
      cfgRdValid && s_reg.rdLat |-> cfgRdData[7:0] == 8'h00 &&
      cfgRdData[31:24] == 8'h00)
      else $error("cache line or self test nonzero");
   a_mem_gate: assert property (
      memClaim |-> $past(s_reg.cmd[CMD_MEM_BIT]) && $past(memDecodeHit))
      else $error("memory claim without enable");
   a_master_gate: assert property (
      busRequest |-> $past(s_reg.cmd[CMD_MASTER_BIT]) &&
      !$past(deviceHalted))
      else $error("bus request without master enable");
   a_special_gate: assert property (
      specialCycleSeen |-> $past(s_reg.cmd[CMD_SPECIAL_BIT]))
      else $error("special cycle seen while disabled");
   a_parity_gate: assert property (
      evt.parityDetected && !swReset |=>
      parityErrorPinOe == $past(s_reg.cmd[CMD_PARITY_BIT]))
      else $error("parity pin does not follow enable");
   a_serr_gate: assert property (
      systemErrorPinOe |-> $past(s_reg.cmd[CMD_SERR_BIT]) &&
      $past(s_reg.sysErrFlag))
      else $error("system error pin without enable");
   a_serr_halts: assert property (
      systemErrorPinOe |-> s_reg.stat[ST_SERR_BIT] && deviceHalted
      ##1 ((deviceHalted && !systemErrorPinOe) || $past(swReset)))
      else $error("no halt or flag after system error");
   a_parity_sticky: assert property (
      evt.parityDetected && !swReset |=> s_reg.stat[ST_PAR_DET_BIT])
      else $error("detected parity flag not set");
   a_abort_flags: assert property (
      evt.targetAbortSent && evt.targetAbortRecv &&
      evt.masterAbortSent && !swReset |=> s_reg.stat[13:11] == 3'b111)
      else $error("abort flags not set");
   a_rep_needs_master: assert property (
      $rose(s_reg.stat[ST_PAR_REP_BIT]) |->
      $past(evt.isMaster) && $past(s_reg.cmd[CMD_PARITY_BIT]))
      else $error("parity reported without cause");
   a_burst_end_grant: assert property (
      burstEnd |-> $past(busGrantPinN) && $past(!framePinN))
      else $error("burst ended while granted");
   a_lat_kept: assert property (
      swReset |=> s_reg.latency == $past(s_reg.latency))
      else $error("latency lost on software reset");
   a_perr_cause: assert property (
      parityErrorPinOe |-> $past(evt.parityDetected) &&
      $past(s_reg.cmd[CMD_PARITY_BIT]))
      else $error("parity pin driven without cause");
   a_spec_follow: assert property (
      specialCycleCmd && s_reg.cmd[CMD_SPECIAL_BIT] && !swReset |=>
      specialCycleSeen)
      else $error("enabled special cycle not seen");
   a_lat_expiry: assert property (
      burstEnd |-> $past(s_reg.latCount) >= $past(s_reg.latency))
      else $error("burst ended before limit");

   // Halt checks skip the entry cycle, whose gates were computed running
   a_halt_no_serr: assert property (
      deviceHalted && $past(deviceHalted) |-> !systemErrorPinOe)
      else $error("system error pin driven twice");
   a_halt_blocks: assert property (
      deviceHalted && $past(deviceHalted) |-> !memClaim && !busRequest)
      else $error("halted device still claims or masters");

   // A pending event must survive a write of zero to its position
   a_evt_hold: assert property (
      s_reg.stat[ST_PAR_DET_BIT] && !swReset &&
      !(cfgReq.wr && cfgReq.addr == CFG_CMD_STAT_OFS && cfgReq.be[3] &&
      cfgReq.data[31]) |=> s_reg.stat[ST_PAR_DET_BIT])
      else $error("detected parity flag lost without clear");
   a_evt_clear: assert property (
      cfgReq.wr && cfgReq.addr == CFG_CMD_STAT_OFS && cfgReq.be[3] &&
      cfgReq.data[31] && !evt.parityDetected |=>
      !s_reg.stat[ST_PAR_DET_BIT])
      else $error("detected parity flag not cleared");

   c_serr_halt: cover property (systemErrorPinOe ##1 deviceHalted);
   c_burst_end: cover property (busGrantPinN ##[1:20] burstEnd);
   c_w1c_clear: cover property (
      s_reg.stat[ST_PAR_DET_BIT] ##1 !s_reg.stat[ST_PAR_DET_BIT]);
   c_mem_claim: cover property (memClaim);
   c_perr_seen: cover property (
      !parityErrorPinInN && !parityErrorPinOe ##1
      s_reg.stat[ST_PAR_REP_BIT]);
endmodule
`default_nettype wire

// ### core/pccs_pkg.sv
// Constants and types for the bus command and status register bank
`default_nettype none
package pccs_pkg;
   // Config-space byte offsets of the words holding this bank
   localparam logic [7:0] CFG_CMD_STAT_OFS = 8'h04;
   localparam logic [7:0] CFG_LAT_OFS = 8'h0C;
   // Command field positions
   localparam int CMD_IO_BIT = 0;
   localparam int CMD_MEM_BIT = 1;
   localparam int CMD_MASTER_BIT = 2;
   localparam int CMD_SPECIAL_BIT = 3;
   localparam int CMD_PARITY_BIT = 6;
   localparam int CMD_SERR_BIT = 8;
   // Status field positions
   localparam int ST_PAR_REP_BIT = 8;
   localparam int ST_SIG_TA_BIT = 11;
   localparam int ST_RCV_TA_BIT = 12;
   localparam int ST_MA_BIT = 13;
   localparam int ST_SERR_BIT = 14;
   localparam int ST_PAR_DET_BIT = 15;
   // Writable command bits and sticky status bits
   localparam logic [15:0] CMD_WR_MASK = 16'h014E;
   localparam logic [15:0] ST_EVT_MASK = 16'hF900;
   // Constant status content: medium decode timing in bits 10:9
   localparam logic [15:0] ST_RO_VALUE = 16'h0200;
   // Values after reset and hardwired bytes
   localparam logic [15:0] CMD_RESET = 16'h0000;
   localparam logic [15:0] ST_RESET = 16'h0000;
   localparam logic [7:0] LAT_RESET = 8'h00;
   localparam logic [7:0] CACHE_LINE_VALUE = 8'h00;
   localparam logic [7:0] HEADER_TYPE_VALUE = 8'h00;
   localparam logic [7:0] SELF_TEST_VALUE = 8'h00;
   localparam logic [7:0] LAT_COUNT_START = 8'h00;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] data;
   } pccs_cfg_req_t;

   typedef struct packed {
      logic isMaster;
      logic targetAbortSent;
      logic targetAbortRecv;
      logic masterAbortSent;
      logic parityDetected;
      logic sysErrCond;
   } pccs_evt_t;

   typedef enum logic [1:0] {
      BURST_IDLE = 2'b00,
      BURST_GRANTED = 2'b01,
      BURST_RELEASED = 2'b11
   } pccs_burst_t;

   typedef enum logic {
      DEV_RUN = 1'b0,
      DEV_HALTED = 1'b1
   } pccs_health_t;

   typedef struct packed {
      logic [15:0] cmd;
      logic [15:0] stat;
      logic [7:0] latency;
      logic [7:0] latCount;
      pccs_burst_t burst;
      pccs_health_t health;
      logic sysErrFlag;
      logic [31:0] rdData;
      logic rdValid;
      logic rdCmd;
      logic rdLat;
      logic memClaim;
      logic busRequest;
      logic specialSeen;
      logic perrOe;
      logic serrOe;
      logic burstEnd;
   } pccs_state_t;

   localparam pccs_state_t STATE_RESET = '{
      cmd: CMD_RESET, stat: ST_RESET, latency: LAT_RESET,
      latCount: LAT_COUNT_START, burst: BURST_IDLE, health: DEV_RUN,
      rdData: 32'h0000_0000, default: 1'b0};
endpackage
`default_nettype wire

// ### sim/pccs_host_model.sv
// Host model issuing configuration reads and writes
`default_nettype none
module pccs_host_model (
   // Clock
   input wire logic core_clk,
   // Configuration access
   output pccs_pkg::pccs_cfg_req_t cfgReq,
   input wire logic [31:0] cfgRdData,
   input wire logic cfgRdValid
);
   timeunit 1ns;
   timeprecision 1ns;
   import pccs_pkg::*;

   initial cfgReq = '0;

   // Released lines show inverted values, never the stale ones
   task automatic cfg_write(input logic [7:0] a, input logic [3:0] b,
      input logic [31:0] d);
      @(posedge core_clk);
      cfgReq <= '{rd: 1'b0, wr: 1'b1, addr: a, be: b, data: d};
      @(posedge core_clk);
      cfgReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, be: ~b, data: ~d};
   endtask

   task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
      int n;
      @(posedge core_clk);
      cfgReq <= '{rd: 1'b1, wr: 1'b0, addr: a, be: 4'hF, data: 32'h0};
      @(posedge core_clk);
      cfgReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, be: 4'h0, data: 32'h0};
      #1;
      n = 0;
      // Bounded wait so a missing answer cannot hang the run
      while (cfgRdValid !== 1'b1 && n < 3) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      d = (cfgRdValid === 1'b1) ? cfgRdData : 'x;
   endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the command and status register bank
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import pccs_pkg::*;

   typedef struct packed {
      logic [7:0] a;
      logic [3:0] b;
      logic [31:0] d;
      logic [31:0] e;
   } pccs_row_t;

   localparam pccs_row_t ROWS [9] = '{
      '{8'h04, 4'hF, 32'hFFFF_FFFF, 32'h0200_014E},
      '{8'h04, 4'hF, 32'h0000_0000, 32'h0200_0000},
      '{8'h04, 4'h1, 32'h0000_0006, 32'h0200_0006},
      '{8'h04, 4'h2, 32'hFFFF_FFFF, 32'h0200_0106},
      '{8'h04, 4'hF, 32'h0000_0000, 32'h0200_0000},
      '{8'h0C, 4'hF, 32'hFFFF_FFFF, 32'h0000_FF00},
      '{8'h0C, 4'h2, 32'h0000_0200, 32'h0000_0200},
      '{8'h10, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000},
      '{8'h40, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000}};

   logic coreClk, rst, swReset, memDecodeHit, masterWant, specialCycleCmd;
   logic busGrantPinN, framePinN, parityErrorPinInN, extPerr;
   pccs_cfg_req_t cfgReq;
   pccs_evt_t evt;
   logic [31:0] cfgRdData;
   logic cfgRdValid, perrOe, serrOe, memClaim, busRequest, specialSeen;
   logic burstEnd, halted, perrOutN, serrOutN;
   int errors = 0;
   int numChecks = 0;
   int serrCount = 0;
   int endCount = 0;

   // Open-drain wire: low while any party drives it
   assign parityErrorPinInN = !(perrOe === 1'b1 || extPerr);

   pccs_command_status i_dut (.core_clk(coreClk), .rst(rst),
      .swReset(swReset), .cfgReq(cfgReq), .cfgRdData(cfgRdData),
      .cfgRdValid(cfgRdValid), .evt(evt), .memDecodeHit(memDecodeHit),
      .masterWant(masterWant), .specialCycleCmd(specialCycleCmd),
      .busGrantPinN(busGrantPinN), .framePinN(framePinN),
      .parityErrorPinInN(parityErrorPinInN), .parityErrorPinOutN(perrOutN),
      .parityErrorPinOe(perrOe), .systemErrorPinOutN(serrOutN),
      .systemErrorPinOe(serrOe), .memClaim(memClaim),
      .busRequest(busRequest), .specialCycleSeen(specialSeen),
      .burstEnd(burstEnd), .deviceHalted(halted));

   pccs_host_model i_host (.core_clk(coreClk), .cfgReq(cfgReq),
      .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid));

   initial begin
      coreClk = 1'b0;
      forever #10 coreClk = ~coreClk;
   end

   always @(posedge coreClk) begin
      if (serrOe === 1'b1)
         serrCount++;
      if (burstEnd === 1'b1)
         endCount++;
   end

   task automatic check32(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t data %h exp %h", $time, got, exp);
      end
   endtask

   task automatic check1(input logic got, input logic exp);
      numChecks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t flag %b exp %b", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      i_host.cfg_read(a, d);
      check32(d, e);
   endtask

   // One-cycle event strobe, returns just after the edge that took it
   task automatic pulse(input logic [5:0] m);
      @(posedge coreClk);
      evt <= evt | m;
      @(posedge coreClk);
      evt <= evt & ~m;
      #1;
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge coreClk);
      #1;
   endtask

   task automatic give_verdict();
      $display("Checks %0d errors %0d", numChecks, errors);
      if (errors == 0 && numChecks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      #100000;
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      give_verdict();
   end

   initial begin
      rst = 1'b1;
      swReset = 1'b0;
      evt = '0;
      memDecodeHit = 1'b0;
      masterWant = 1'b0;
      specialCycleCmd = 1'b0;
      busGrantPinN = 1'b1;
      framePinN = 1'b1;
      extPerr = 1'b0;
      repeat (3) @(posedge coreClk);
      rst <= 1'b0;
      rd_chk(CFG_CMD_STAT_OFS, 32'h0200_0000);
      rd_chk(CFG_LAT_OFS, 32'h0000_0000);
      foreach (ROWS[i]) begin
         i_host.cfg_write(ROWS[i].a, ROWS[i].b, ROWS[i].d);
         rd_chk(ROWS[i].a, ROWS[i].e);
      end
      @(posedge coreClk);
      memDecodeHit <= 1'b1;
      masterWant <= 1'b1;
      specialCycleCmd <= 1'b1;
      wait_n(3);
      check1(memClaim, 1'b0);
      check1(busRequest, 1'b0);
      check1(specialSeen, 1'b0);
      i_host.cfg_write(8'h04, 4'h3, 32'h0000_000E);
      wait_n(2);
      check1(memClaim, 1'b1);
      check1(busRequest, 1'b1);
      check1(specialSeen, 1'b1);
      // Parity error with response disabled and no mastership
      pulse(6'h02);
      check1(perrOe, 1'b0);
      rd_chk(8'h04, 32'h8200_000E);
      i_host.cfg_write(8'h04, 4'hC, 32'hFFFF_0000);
      rd_chk(8'h04, 32'h0200_000E);
      i_host.cfg_write(8'h04, 4'h1, 32'h0000_004E);
      @(posedge coreClk);
      evt.isMaster <= 1'b1;
      pulse(6'h02);
      check1(perrOe, 1'b1);
      check1(perrOutN, 1'b0);
      wait_n(1);
      check1(perrOe, 1'b0);
      rd_chk(8'h04, 32'h8300_004E);
      pulse(6'h1C);
      rd_chk(8'h04, 32'hBB00_004E);
      i_host.cfg_write(8'h04, 4'hC, 32'hFFFF_0000);
      rd_chk(8'h04, 32'h0200_004E);
      // Long burst with grant held, then grant withdrawn
      @(posedge coreClk);
      busGrantPinN <= 1'b0;
      framePinN <= 1'b0;
      wait_n(10);
      check32(endCount, 0);
      @(posedge coreClk);
      busGrantPinN <= 1'b1;
      wait_n(3);
      @(posedge coreClk);
      framePinN <= 1'b1;
      wait_n(2);
      check32(endCount, 1);
      // Target pulls the parity pin while we are master
      @(posedge coreClk);
      extPerr <= 1'b1;
      @(posedge coreClk);
      extPerr <= 1'b0;
      rd_chk(8'h04, 32'h0300_004E);
      i_host.cfg_write(8'h04, 4'hC, 32'hFFFF_0000);
      // System error held back until its enable is set
      pulse(6'h01);
      wait_n(4);
      check32(serrCount, 0);
      check1(halted, 1'b0);
      i_host.cfg_write(8'h04, 4'h2, 32'h0000_0100);
      wait_n(4);
      check32(serrCount, 1);
      check1(halted, 1'b1);
      check1(memClaim, 1'b0);
      check1(serrOutN, 1'b0);
      rd_chk(8'h04, 32'h4200_014E);
      @(posedge coreClk);
      swReset <= 1'b1;
      @(posedge coreClk);
      swReset <= 1'b0;
      rd_chk(8'h04, 32'h0200_0000);
      rd_chk(8'h0C, 32'h0000_0200);
      check1(halted, 1'b0);
      @(posedge coreClk);
      rst <= 1'b1;
      repeat (2) @(posedge coreClk);
      rst <= 1'b0;
      rd_chk(8'h0C, 32'h0000_0000);
      check1(memClaim, 1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire
